// [sic_assertions.sv]
// checker for the status indicator block
`timescale 1ns/1ps
module sic_chk (
  input wire clk,
  input wire rst_n,
  input wire ce,
  input wire [7:0] addr,
  input wire [15:0] wdata,
  input wire wr,
  input wire rd,
  input wire [15:0] rdata,
  input wire speed_100,
  input wire link_up,
  input wire tx_evt,
  input wire rx_evt,
  input wire ind1_on,
  input wire ind2_on
);
  reg [15:0] cfg_r;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      cfg_r <= 16'h0422;
    else if (ce && wr && addr == 8'h14)
      cfg_r <= wdata & 16'hFFFE;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_cfg_read: assert property (ce && rd && addr == 8'h14 |=> rdata == $past(cfg_r))
    else $error("cfg read");
  a_speed_ind: assert property (ce && cfg_r[15:12] == 4'h0 |=> ind1_on == $past(speed_100))
    else $error("speed");
  a_link_ind: assert property (ce && cfg_r[11:8] == 4'h4 |=> ind2_on == $past(link_up))
    else $error("link");
  a_force_on: assert property (ce && cfg_r[15:12] == 4'h8 |=> ind1_on)
    else $error("force on");
  a_force_off: assert property (ce && cfg_r[11:8] == 4'h9 |=> !ind2_on)
    else $error("force off");
  a_raw_tx: assert property (ce && !cfg_r[1] && cfg_r[15:12] == 4'h1 |=> ind1_on == $past(tx_evt))
    else $error("raw tx");
  a_tx_held: assert property (ce && cfg_r[1] && cfg_r[15:12] == 4'h1 && tx_evt |=> ind1_on)
    else $error("tx held");
  a_cmb_toggle: assert property (ce && cfg_r[15:12] == 4'hC && rx_evt ##1 (ce && !rx_evt && cfg_r[15:12] == 4'hC) |=> ind1_on == !$past(link_up))
    else $error("combined");
  c_read: cover property (ce && rd);
  c_stretch: cover property (cfg_r[15:12] == 4'h1 && $fell(ind1_on));
  c_comb: cover property (cfg_r[15:12] == 4'hC && $fell(ind1_on));
endmodule
bind sic_top sic_chk u_chk (.clk(clk), .rst_n(rst_n), .ce(ce), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
  .rdata(rdata), .speed_100(speed_100), .link_up(link_up), .tx_evt(tx_evt), .rx_evt(rx_evt), .ind1_on(ind1_on),
  .ind2_on(ind2_on));

// [sic_consts.vh]
// constants for the status indicator configuration block
// Functional notes
// - indicator one source resets to speed
// - codes 1-3 show stretched transmit, receive, collision
// - code 5 duplex, code 7 stretched activity
// - code 8 forces on, 9 forces off
// - code 10 blinks fast, 11 slow
// - indicator two source resets to link
// - indicator three resets to receive; 15 unused
// - codes 12-14 show combined stretched displays
// - link held solid on as primary
// - receive or activity event toggles indicator
// - full duplex solid, collision toggles indicator
// - period field 30/60/100 ms, resets 00
// - global stretch enable resets 1, gates stretching
// - combined displays stretched regardless of enable
`ifndef SIC_CONSTS_VH
`define SIC_CONSTS_VH

`define SIC_OFS_CFG 8'h14
`define SIC_OFS_STAT 8'h18
`define SIC_CFG_RESET 16'h0422
`define SIC_CFG_WMASK 16'hFFFE
`define SIC_IND1_HI 15
`define SIC_IND1_LO 12
`define SIC_IND2_HI 11
`define SIC_IND2_LO 8
`define SIC_IND3_HI 7
`define SIC_IND3_LO 4
`define SIC_PER_HI 3
`define SIC_PER_LO 2
`define SIC_STR_EN_BIT 1

`define SIC_SRC_SPEED 4'h0
`define SIC_SRC_TX 4'h1
`define SIC_SRC_RX 4'h2
`define SIC_SRC_COL 4'h3
`define SIC_SRC_LINK 4'h4
`define SIC_SRC_DUPLEX 4'h5
`define SIC_SRC_UNUSED6 4'h6
`define SIC_SRC_ACT 4'h7
`define SIC_SRC_ON 4'h8
`define SIC_SRC_OFF 4'h9
`define SIC_SRC_FAST 4'hA
`define SIC_SRC_SLOW 4'hB
`define SIC_SRC_LINK_RX 4'hC
`define SIC_SRC_LINK_ACT 4'hD
`define SIC_SRC_DUP_COL 4'hE
`define SIC_SRC_UNUSED15 4'hF

`define SIC_PER_30 2'h0
`define SIC_PER_60 2'h1
`define SIC_PER_100 2'h2

`define SIC_CLK_KHZ 200000
`define SIC_T30_MS 30
`define SIC_T60_MS 60
`define SIC_T100_MS 100
`define SIC_FAST_HALF_MS 25
`define SIC_SLOW_HALF_MS 100
`define SIC_CNT_W 25
`define SIC_T30_CYC 25'h05B8D80
`define SIC_T60_CYC 25'h0B71B00
`define SIC_T100_CYC 25'h1312D00
`define SIC_FAST_HALF_CYC 25'h04C4B40
`define SIC_SLOW_HALF_CYC 25'h1312D00

`endif

// [sic_lamp.sv]
// lamp model: counts how often a lamp lights up
`timescale 1ns/1ps
module sic_lamp (
  input wire clk,
  input wire rst_n,
  input wire on,
  output integer rises
);
  reg lit_r;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lit_r <= 1'h0;
      rises <= 0;
    end else begin
      lit_r <= on;
      if (on && !lit_r)
        rises <= rises + 1;
    end
  end
endmodule

// [sic_stretch.v]
// event stretcher: holds an event for a programmable number of cycles
`timescale 1ns/1ps
module sic_stretch (
  input wire clk,
  input wire rst_n,
  input wire ce,
  input wire evt,
  input wire [24:0] period,
  output wire held
);
  reg [24:0] cnt_r;
  reg [24:0] cnt_nxt;

  always @* begin
    cnt_nxt = cnt_r;
    if (evt) begin
      cnt_nxt = period;
    end else if (cnt_r != 25'h0000000) begin
      cnt_nxt = cnt_r - 25'h0000001;
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= 25'h0000000;
    end else if (ce) begin
      cnt_r <= cnt_nxt;
    end
  end

  // active during the event and until the count runs out
  assign held = evt | (cnt_r != 25'h0000000);
endmodule

// [sic_top.v]
// status indicator configuration register and indicator drivers
//
// The implementer's own choice: strobed register access.
`timescale 1ns/1ps
`include "sic_consts.vh"
module sic_top #(
  parameter [24:0] STRETCH_30_CYC = `SIC_T30_CYC,
  parameter [24:0] STRETCH_60_CYC = `SIC_T60_CYC,
  parameter [24:0] STRETCH_100_CYC = `SIC_T100_CYC,
  parameter [24:0] FAST_HALF_CYC = `SIC_FAST_HALF_CYC,
  parameter [24:0] SLOW_HALF_CYC = `SIC_SLOW_HALF_CYC
) (
  input wire clk,
  input wire rst_n,
  input wire ce,
  input wire [7:0] addr,
  input wire [15:0] wdata,
  input wire wr,
  input wire rd,
  output wire [15:0] rdata,
  input wire speed_100,
  input wire link_up,
  input wire full_duplex,
  input wire tx_evt,
  input wire rx_evt,
  input wire col_evt,
  output wire ind1_on,
  output wire ind2_on,
  output wire ind3_on
);
  reg [15:0] cfg_r;
  reg [15:0] cfg_nxt;
  reg [15:0] rdata_r;
  reg [15:0] rdata_nxt;
  reg [24:0] fast_cnt_r;
  reg [24:0] fast_cnt_nxt;
  reg [24:0] slow_cnt_r;
  reg [24:0] slow_cnt_nxt;
  reg fast_r;
  reg fast_nxt;
  reg slow_r;
  reg slow_nxt;
  reg ind1_r;
  reg ind2_r;
  reg ind3_r;
  reg [24:0] period;
  wire [3:0] src1;
  wire [3:0] src2;
  wire [3:0] src3;
  wire [1:0] per_sel;
  wire str_en;
  wire act_evt;
  wire tx_held;
  wire rx_held;
  wire col_held;
  wire act_held;
  wire tx_show;
  wire rx_show;
  wire col_show;
  wire act_show;
  wire link_rx_show;
  wire link_act_show;
  wire dup_col_show;
  wire [15:0] disp;
  wire ind1_nxt;
  wire ind2_nxt;
  wire ind3_nxt;

  // picks the display value for one source code
  function sic_pick;
    input [3:0] code;
    input [15:0] vec;
    begin
      sic_pick = vec[code];
    end
  endfunction

  // register file fields
  assign src1 = cfg_r[`SIC_IND1_HI:`SIC_IND1_LO];
  assign src2 = cfg_r[`SIC_IND2_HI:`SIC_IND2_LO];
  assign src3 = cfg_r[`SIC_IND3_HI:`SIC_IND3_LO];
  assign per_sel = cfg_r[`SIC_PER_HI:`SIC_PER_LO];
  assign str_en = cfg_r[`SIC_STR_EN_BIT];

  // configuration register write
  always @* begin
    cfg_nxt = cfg_r;
    if (wr && (addr == `SIC_OFS_CFG)) begin
      cfg_nxt = wdata & `SIC_CFG_WMASK;
    end
  end

  // one cycle read data, zero for unmapped addresses
  always @* begin
    rdata_nxt = 16'h0000;
    if (rd) begin
      case (addr)
        `SIC_OFS_CFG: begin
          rdata_nxt = cfg_r;
        end
        `SIC_OFS_STAT: begin
          rdata_nxt[0] = ind1_r;
          rdata_nxt[1] = ind2_r;
          rdata_nxt[2] = ind3_r;
          rdata_nxt[4] = speed_100;
          rdata_nxt[5] = link_up;
          rdata_nxt[6] = full_duplex;
          rdata_nxt[8] = tx_held;
          rdata_nxt[9] = rx_held;
          rdata_nxt[10] = col_held;
          rdata_nxt[11] = act_held;
          rdata_nxt[12] = fast_r;
          rdata_nxt[13] = slow_r;
        end
        default: begin
          rdata_nxt = 16'h0000;
        end
      endcase
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_r <= `SIC_CFG_RESET;
      rdata_r <= 16'h0000;
    end else if (ce) begin
      cfg_r <= cfg_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign rdata = rdata_r;

  // stretch period select, reserved code falls back to the shortest
  always @* begin
    case (per_sel)
      `SIC_PER_30: begin
        period = STRETCH_30_CYC;
      end
      `SIC_PER_60: begin
        period = STRETCH_60_CYC;
      end
      `SIC_PER_100: begin
        period = STRETCH_100_CYC;
      end
      default: begin
        period = STRETCH_30_CYC;
      end
    endcase
  end

  // free-running blink dividers
  always @* begin
    fast_cnt_nxt = fast_cnt_r + 25'h0000001;
    fast_nxt = fast_r;
    if (fast_cnt_r >= FAST_HALF_CYC - 25'h0000001) begin
      fast_cnt_nxt = 25'h0000000;
      fast_nxt = ~fast_r;
    end
  end

  always @* begin
    slow_cnt_nxt = slow_cnt_r + 25'h0000001;
    slow_nxt = slow_r;
    if (slow_cnt_r >= SLOW_HALF_CYC - 25'h0000001) begin
      slow_cnt_nxt = 25'h0000000;
      slow_nxt = ~slow_r;
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fast_cnt_r <= 25'h0000000;
      slow_cnt_r <= 25'h0000000;
      fast_r <= 1'b0;
      slow_r <= 1'b0;
    end else if (ce) begin
      fast_cnt_r <= fast_cnt_nxt;
      slow_cnt_r <= slow_cnt_nxt;
      fast_r <= fast_nxt;
      slow_r <= slow_nxt;
    end
  end

  // activity is receive or transmit
  assign act_evt = rx_evt | tx_evt;

  // event stretchers, always running so combined displays can use them
  sic_stretch u_tx (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .evt(tx_evt),
    .period(period),
    .held(tx_held)
  );

  sic_stretch u_rx (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .evt(rx_evt),
    .period(period),
    .held(rx_held)
  );

  sic_stretch u_col (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .evt(col_evt),
    .period(period),
    .held(col_held)
  );

  sic_stretch u_act (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .evt(act_evt),
    .period(period),
    .held(act_held)
  );

  // single-event displays follow the global enable
  assign tx_show = str_en ? tx_held : tx_evt;
  assign rx_show = str_en ? rx_held : rx_evt;
  assign col_show = str_en ? col_held : col_evt;
  assign act_show = str_en ? act_held : act_evt;

  // combined displays use the stretched events unconditionally
  assign link_rx_show = link_up ^ rx_held;
  assign link_act_show = link_up ^ act_held;
  assign dup_col_show = full_duplex ^ col_held;

  // display value for every source code
  assign disp[`SIC_SRC_SPEED] = speed_100;
  assign disp[`SIC_SRC_TX] = tx_show;
  assign disp[`SIC_SRC_RX] = rx_show;
  assign disp[`SIC_SRC_COL] = col_show;
  assign disp[`SIC_SRC_LINK] = link_up;
  assign disp[`SIC_SRC_DUPLEX] = full_duplex;
  assign disp[`SIC_SRC_UNUSED6] = 1'b0;
  assign disp[`SIC_SRC_ACT] = act_show;
  assign disp[`SIC_SRC_ON] = 1'b1;
  assign disp[`SIC_SRC_OFF] = 1'b0;
  assign disp[`SIC_SRC_FAST] = fast_r;
  assign disp[`SIC_SRC_SLOW] = slow_r;
  assign disp[`SIC_SRC_LINK_RX] = link_rx_show;
  assign disp[`SIC_SRC_LINK_ACT] = link_act_show;
  assign disp[`SIC_SRC_DUP_COL] = dup_col_show;
  assign disp[`SIC_SRC_UNUSED15] = 1'b0;

  // per-indicator selection
  assign ind1_nxt = sic_pick(src1, disp);
  assign ind2_nxt = sic_pick(src2, disp);
  assign ind3_nxt = sic_pick(src3, disp);

  // registered lamp drives
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ind1_r <= 1'b0;
      ind2_r <= 1'b0;
      ind3_r <= 1'b0;
    end else if (ce) begin
      ind1_r <= ind1_nxt;
      ind2_r <= ind2_nxt;
      ind3_r <= ind3_nxt;
    end
  end

  assign ind1_on = ind1_r;
  assign ind2_on = ind2_r;
  assign ind3_on = ind3_r;
endmodule

// [tb.sv]
// self-checking bench for the status indicator block
`timescale 1ns/1ps
`include "sic_consts.vh"
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin mismatches++; $display("[FAIL] %0t %h %h", $time, a, e); end end
module tb;
  reg clk = 0, rst_n = 0, ce = 1, wr = 0, rd = 0, sp = 1, lk = 0, fd = 0, tx = 0, rx = 1, cl = 0;
  reg [7:0] addr = 8'h00;
  reg [15:0] wdata = 16'h0000, seed = 16'h0004, cfg_m = 16'h0422, d;
  wire [15:0] rdata;
  wire i1, i2, i3;
  integer mismatches = 0, n_checks = 0, c, p, n, f, rises;
  sic_top #(.STRETCH_30_CYC(25'd30), .STRETCH_60_CYC(25'd60), .STRETCH_100_CYC(25'd100), .FAST_HALF_CYC(25'd4),
    .SLOW_HALF_CYC(25'd16)) u_dut (.clk(clk), .rst_n(rst_n), .ce(ce), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .speed_100(sp), .link_up(lk), .full_duplex(fd), .tx_evt(tx), .rx_evt(rx),
    .col_evt(cl), .ind1_on(i1), .ind2_on(i2), .ind3_on(i3));
  sic_lamp u_lamp (.clk(clk), .rst_n(rst_n), .on(i1), .rises(rises));
  function [15:0] lfsr(input [15:0] s);
    lfsr = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function exp_ind(input [3:0] k);
    reg [15:0] v;
    v = {1'h0, fd ^ cl, lk ^ (tx | rx), lk ^ rx, 4'h1, tx | rx, 1'h0, fd, lk, cl, rx, tx, sp};
    exp_ind = v[k];
  endfunction
  task wr_reg(input [7:0] a, input [15:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'h1;
    @(posedge clk);
    wr <= 1'h0;
    if (a == `SIC_OFS_CFG)
      cfg_m = v & 16'hFFFE;
  endtask
  task rd_reg(input [7:0] a);
    @(posedge clk);
    addr <= a;
    rd <= 1'h1;
    @(posedge clk);
    rd <= 1'h0;
    #1 d = rdata;
  endtask
  task end_of_test;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    forever #2.5 clk = ~clk;
  end
  initial begin
    #100000;
    mismatches++;
    end_of_test;
  end
  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'h1;
    rd_reg(`SIC_OFS_CFG);
    `CHK(d, cfg_m)
    `CHK({i1, i2, i3}, 3'h5)
    rd_reg(`SIC_OFS_STAT);
    `CHK(d & 16'hCFFF, {4'h0, tx | rx, cl, rx, tx, 1'h0, fd, lk, sp, 1'h0, rx, lk, sp})
    rd_reg(8'h30);
    `CHK(d, 16'h0000)
    for (n = 0; n < 4; n++) begin
      seed = lfsr(seed);
      wr_reg(`SIC_OFS_CFG, seed);
      wr_reg(`SIC_OFS_STAT, ~seed);
      rd_reg(`SIC_OFS_CFG);
      `CHK(d, cfg_m)
    end
    for (p = 0; p < 2; p++) begin
      seed = lfsr(seed);
      @(posedge clk);
      {sp, lk, fd, tx, rx, cl} <= seed[5:0];
      repeat (110) @(posedge clk);
      for (c = 0; c < 16; c++) begin
        wr_reg(`SIC_OFS_CFG, {{3{c[3:0]}}, 4'h0});
        repeat (2) @(posedge clk);
        #1;
        if (c < 10 || c > 11)
          `CHK({i1, i2, i3}, {3{exp_ind(c[3:0])}})
      end
    end
    @(posedge clk);
    {sp, lk, fd, tx, rx, cl} <= 6'h00;
    for (p = 0; p < 6; p++) begin
      wr_reg(`SIC_OFS_CFG, {p == 5 ? 4'hC : 4'h1, 8'h00, p[1:0], !p[2], 1'h0});
      repeat (110) @(posedge clk);
      {tx, rx} <= 2'h3;
      n = 0;
      repeat (121) begin
        @(posedge clk);
        {tx, rx} <= 2'h0;
        #1 n = n + i1;
      end
      `CHK(n, p == 4 ? 1 : p == 2 ? 101 : p % 4 == 1 ? 61 : 31)
    end
    wr_reg(`SIC_OFS_CFG, 16'hA000);
    f = rises;
    repeat (160) @(posedge clk);
    f = rises - f;
    wr_reg(`SIC_OFS_CFG, 16'hB000);
    n = rises;
    repeat (160) @(posedge clk);
    n = rises - n;
    `CHK(f > 18 && f < 22, 1'h1)
    `CHK(n > 3 && n < 7, 1'h1)
    ce <= 1'h0;
    repeat (2) @(posedge clk);
    n = rises;
    wr_reg(`SIC_OFS_CFG, 16'h8000);
    repeat (62) @(posedge clk);
    `CHK(rises - n, 0)
    ce <= 1'h1;
    rd_reg(`SIC_OFS_CFG);
    `CHK(d, 16'hB000)
    end_of_test;
  end
endmodule
